// file: core/hspds_pkg.sv
// Shared constants and carrier types for the heat-seal process data block
package hspds_pkg;

  // Set point ceilings per temperature range, in degrees C
  localparam logic [15:0] HSPDS_SP_MAX_LOW   = 16'h012C;  // 300
  localparam logic [15:0] HSPDS_SP_MAX_HIGH  = 16'h01F4;  // 500
  // Start temperature word when not valid: -99 degrees C
  localparam logic [15:0] HSPDS_START_INVAL  = 16'hFF9D;
  // Tolerance band limit magnitude ceiling, kelvin
  localparam logic [6:0]  HSPDS_TOL_MAX      = 7'h63;     // 99
  // Reached threshold as a ratio of 95 to 100
  localparam logic signed [24:0] HSPDS_REACH_NUM = 25'sh000_005F;
  localparam logic signed [24:0] HSPDS_REACH_DEN = 25'sh000_0064;

  // Window function modes; code 3 behaves as the factory setting
  localparam logic [1:0]  HSPDS_WIN_OFF      = 2'h0;
  localparam logic [1:0]  HSPDS_WIN_FOLLOW   = 2'h1;
  localparam logic [1:0]  HSPDS_WIN_LATCH    = 2'h2;

  // Reset values and channel count
  localparam logic [15:0] HSPDS_WORD_RST     = 16'h0000;
  localparam logic [2:0]  HSPDS_CHAN_RST     = 3'h0;
  localparam logic [9:0]  HSPDS_CODE_RST     = 10'h000;
  localparam int unsigned HSPDS_CHANNELS     = 8;

  // Control word from the master
  typedef struct packed {
    logic [2:0] calibration_channel_select;
    logic       reference_calibration_request;
    logic       zero_calibration_request;
    logic       measurement_pause_request;
    logic       fault_clear_request;
    logic       heat_request;
  } hspds_ctrl_type;

  // Status word to the master, bit 0 first from the right
  typedef struct packed {
    logic [2:0] zero_pad;
    logic [2:0] channel_in_use;
    logic       measurement_gap_flag;
    logic       standby_flag;
    logic       reserved_info_flag;
    logic       control_mode_flag;
    logic       temperature_window_flag;
    logic       temperature_reached_flag;
    logic       warning_flag;
    logic       alarm_flag;
    logic       calibration_blocked_flag;
    logic       calibration_running_flag;
  } hspds_status_type;

  // Events and values from the measurement and control engine
  typedef struct packed {
    logic        cal_done;
    logic        cal_ok;
    logic        phase_comp_busy;
    logic        meas_active;
    logic        cooling_active;
    logic        powerup_hold;
    logic        alarm_trigger;
    logic        alarm_is_warning;
    logic [9:0]  alarm_code;
    logic [15:0] meas_resistance;
    logic [15:0] actual_temp;
  } hspds_engine_type;

endpackage : hspds_pkg

// file: core/hspds_temp_compare.sv
// Tolerance band and reached-threshold comparator for the actual value
`timescale 1ns/1ns
module hspds_temp_compare
  import hspds_pkg::*;
(
  // Values to compare
  input  wire logic [15:0] actual,
  input  wire logic [15:0] set_point,
  input  wire logic [6:0]  tol_high,
  input  wire logic [6:0]  tol_low,
  // Results
  output logic             in_band,
  output logic             above_reach
);

  logic signed [17:0] act_s;
  logic signed [17:0] hi_s;
  logic signed [17:0] lo_s;
  logic signed [24:0] act_x;
  logic signed [24:0] set_x;

  // Band edges, widened so set point plus limit cannot wrap
  assign act_s = {{2{actual[15]}}, actual};
  assign hi_s  = $signed({2'h0, set_point}) + $signed({11'h000, tol_high});
  assign lo_s  = $signed({2'h0, set_point}) - $signed({11'h000, tol_low});
  assign in_band = (act_s >= lo_s) && (act_s <= hi_s);

  // Ratio test avoids a divider: actual*100 > set*95
  assign act_x = 25'(act_s) * HSPDS_REACH_DEN;
  assign set_x = $signed({9'h000, set_point}) * HSPDS_REACH_NUM;
  assign above_reach = act_x > set_x;

endmodule : hspds_temp_compare

// file: core/hspds_status.sv
// Process data control and status logic of the heat-seal controller
//
// What this block does
// - Successful reference calibration also stores band resistance as channel reference
// - After each successful ordinary calibration, deviation from reference is computed and readable
// - Eight calibration records, chosen by a three-bit channel select whenever no calibration is running
// - Channel change during calibration waits until that calibration finishes
// - Channel in use is shown in the status word
// - Set point above range maximum (300 or 500 C) is clamped to it
// - Calibration running flag covers zero calibration and phase compensation
// - Calibration blocked flag while heat request, cooling or other refusal
// - Alarm flag sets on trigger and stays until fault clear
// - Warning may accompany alarm; alarm relay stays off for warnings
// - Reached flag above 95% of set point; clears on heat drop or alarm
// - Window mode off holds the temperature window flag at zero
// - Follow mode: window flag tracks band membership regardless of control mode
// - Latch mode: set on first entry, clear on exit while heating, else hold
// - Upper and lower band limits independent, each up to 99 K
// - Control mode flag only when heat request accepted and control entered
// - Reserved info flag always zero
// - Standby flag when fault clear or pause accepted; master drops request after
// - Measurement gap flag while heating without measurement; clears when measuring
// - Actual value signed 16-bit, 1 C; zero during calibration or fault
// - Start temperature valid while heating, else minus 99
// - Fault code in bits 0 to 9 of the third output word
`timescale 1ns/1ns
module hspds_status
  import hspds_pkg::*;
(
  // Clock, reset and freeze
  input  wire logic             SYS_CLK,
  input  wire logic             RESET_N,
  input  wire logic             CLK_EN,
  // Cyclic data from the master
  input  wire logic [15:0]      SET_POINT_IN,
  input  wire hspds_ctrl_type   CONTROL_IN,
  // Configuration
  input  wire logic             RANGE_UPPER,
  input  wire logic [1:0]       WINDOW_MODE,
  input  wire logic [6:0]       TOL_HIGH,
  input  wire logic [6:0]       TOL_LOW,
  input  wire logic             START_TEMP_ENABLE,
  // Measurement and control engine
  input  wire hspds_engine_type ENGINE_IN,
  // Commands to the engine
  output logic                  CAL_START,
  output logic                  HEAT_ENABLE,
  output logic                  ALARM_RELAY,
  output logic [15:0]           SET_POINT_OUT,
  // Cyclic data to the master
  output logic [15:0]           ACTUAL_OUT,
  output hspds_status_type      STATUS_OUT,
  output logic [15:0]           ERROR_OUT,
  output logic [15:0]           START_TEMP_OUT,
  output logic [15:0]           DEVIATION_OUT
);

  typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_RELEASE} hspds_cal_type;

  hspds_cal_type cal_state_r;
  hspds_cal_type cal_state_nxt;
  logic [15:0]   rec_r [HSPDS_CHANNELS];
  logic [15:0]   ref_r [HSPDS_CHANNELS];
  logic          ref_mode_r;
  logic [2:0]    chan_r;
  logic [2:0]    chan_nxt;
  logic          cal_start_r;
  logic [15:0]   dev_r;
  logic [15:0]   sp_r;
  logic          running_r;
  logic          blocked_r;
  logic          control_r;
  logic          alarm_r;
  logic          warn_r;
  logic [9:0]    code_r;
  logic          reached_r;
  logic          window_r;
  logic          entered_r;
  logic          standby_r;
  logic          gap_r;
  logic [15:0]   actual_r;
  logic [15:0]   prev_temp_r;
  logic [15:0]   start_cap_r;
  logic [15:0]   start_out_r;
  logic          heat_prev_r;

  // Decoded requests and conditions
  wire         heat_req    = CONTROL_IN.heat_request;
  wire         clr_req     = CONTROL_IN.fault_clear_request;
  wire         pause_req   = CONTROL_IN.measurement_pause_request;
  wire         ref_req     = CONTROL_IN.reference_calibration_request;
  wire         cal_req     = CONTROL_IN.zero_calibration_request | ref_req;
  wire         blocked_nxt = heat_req | clr_req | ENGINE_IN.cooling_active
                             | ENGINE_IN.powerup_hold;
  wire         cal_go      = (cal_state_r == CAL_IDLE) & cal_req & ~blocked_nxt & ~alarm_r;
  wire         cal_fin     = (cal_state_r == CAL_RUN) & ENGINE_IN.cal_done;
  wire         cal_store   = cal_fin & ENGINE_IN.cal_ok;
  wire         running_nxt = (cal_state_nxt == CAL_RUN) | ENGINE_IN.phase_comp_busy;
  wire         alarm_nxt   = ENGINE_IN.alarm_trigger | (alarm_r & ~clr_req);
  wire         warn_nxt    = ENGINE_IN.alarm_trigger ? ENGINE_IN.alarm_is_warning
                                                     : (warn_r & alarm_nxt);
  wire         control_nxt = heat_req & ~running_nxt & ~alarm_nxt & ~clr_req;
  wire         heat_start  = heat_req & ~heat_prev_r;

  // Set point ceiling by range; master values above it are cut
  wire  [15:0] sp_max      = RANGE_UPPER ? HSPDS_SP_MAX_HIGH : HSPDS_SP_MAX_LOW;
  wire  [15:0] sp_nxt      = (SET_POINT_IN > sp_max) ? sp_max : SET_POINT_IN;

  // Band limits saturate at 99 K so a wild parameter cannot widen the band
  wire  [6:0]  tol_hi      = (TOL_HIGH > HSPDS_TOL_MAX) ? HSPDS_TOL_MAX : TOL_HIGH;
  wire  [6:0]  tol_lo      = (TOL_LOW > HSPDS_TOL_MAX) ? HSPDS_TOL_MAX : TOL_LOW;

  wire         in_band;
  wire         above_reach;

  hspds_temp_compare u_cmp (
    .actual      (ENGINE_IN.actual_temp),
    .set_point   (sp_r),
    .tol_high    (tol_hi),
    .tol_low     (tol_lo),
    .in_band     (in_band),
    .above_reach (above_reach)
  );

  // Reached holds once crossed; leaving control mode or an alarm drops it
  wire         reached_nxt = control_nxt & (reached_r | above_reach);

  // Latch mode: first entry per heat cycle sets, exit while heating clears
  wire         latch_set   = in_band & (heat_start | ~entered_r);
  wire         latch_nxt   = heat_start ? in_band
                           : heat_req ? (latch_set | (window_r & in_band))
                           : window_r;
  wire         entered_nxt = heat_start ? in_band : (entered_r | (heat_req & in_band));
  wire         window_nxt  = (WINDOW_MODE == HSPDS_WIN_OFF)   ? 1'b0
                           : (WINDOW_MODE == HSPDS_WIN_LATCH) ? latch_nxt
                           : in_band;

  // Pause only counts in plain measurement; heat, clear and calibration win
  wire         pause_ok    = pause_req & ~heat_req & ~cal_req & ~running_nxt;
  wire         standby_nxt = clr_req | pause_ok
                           | (standby_r & (clr_req | pause_req));
  wire         gap_nxt     = control_nxt & ~ENGINE_IN.meas_active;

  // Actual value: zero in calibration, fault or clear; frozen in pause
  wire  [15:0] actual_nxt  = (running_nxt | alarm_nxt | clr_req) ? HSPDS_WORD_RST
                           : pause_ok ? actual_r
                           : ENGINE_IN.actual_temp;
  wire  [15:0] start_nxt   = (START_TEMP_ENABLE & heat_req)
                           ? (heat_start ? prev_temp_r : start_cap_r)
                           : HSPDS_START_INVAL;
  wire  [9:0]  code_nxt    = ENGINE_IN.alarm_trigger ? ENGINE_IN.alarm_code
                           : alarm_nxt ? code_r : HSPDS_CODE_RST;

  // Idle tracks the select; a running calibration keeps its channel
  assign chan_nxt = (cal_state_r == CAL_RUN) ? chan_r
                  : CONTROL_IN.calibration_channel_select;

  // Calibration sequencer; a held request runs only once
  always_comb begin
    cal_state_nxt = cal_state_r;
    case (cal_state_r)
      CAL_IDLE:    if (cal_go) cal_state_nxt = CAL_RUN;
      CAL_RUN:     if (cal_fin) cal_state_nxt = CAL_RELEASE;
      CAL_RELEASE: if (!cal_req) cal_state_nxt = CAL_IDLE;
      default:     cal_state_nxt = CAL_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cal_state_r <= CAL_IDLE;
      ref_mode_r  <= 1'b0;
      chan_r      <= HSPDS_CHAN_RST;
      cal_start_r <= 1'b0;
    end else if (CLK_EN) begin
      cal_state_r <= cal_state_nxt;
      chan_r      <= chan_nxt;
      cal_start_r <= cal_go;
      if (cal_go) ref_mode_r <= ref_req;
    end
  end

  // Calibration records and reference values per channel
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < HSPDS_CHANNELS; i++) begin
        rec_r[i] <= HSPDS_WORD_RST;
        ref_r[i] <= HSPDS_WORD_RST;
      end
      dev_r <= HSPDS_WORD_RST;
    end else if (CLK_EN && cal_store) begin
      rec_r[chan_r] <= ENGINE_IN.meas_resistance;
      if (ref_mode_r) begin
        ref_r[chan_r] <= ENGINE_IN.meas_resistance;
        dev_r         <= HSPDS_WORD_RST;
      end else begin
        dev_r <= ENGINE_IN.meas_resistance - ref_r[chan_r];
      end
    end
  end

  // Alarm, warning and code; a trigger beats a same-cycle clear
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      alarm_r <= 1'b0;
      warn_r  <= 1'b0;
      code_r  <= HSPDS_CODE_RST;
    end else if (CLK_EN) begin
      alarm_r <= alarm_nxt;
      warn_r  <= warn_nxt;
      code_r  <= code_nxt;
    end
  end

  // Status flags
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      running_r <= 1'b0;
      blocked_r <= 1'b0;
      control_r <= 1'b0;
      reached_r <= 1'b0;
      window_r  <= 1'b0;
      entered_r <= 1'b0;
      standby_r <= 1'b0;
      gap_r     <= 1'b0;
    end else if (CLK_EN) begin
      running_r <= running_nxt;
      blocked_r <= blocked_nxt;
      control_r <= control_nxt;
      reached_r <= reached_nxt;
      window_r  <= window_nxt;
      entered_r <= entered_nxt;
      standby_r <= standby_nxt;
      gap_r     <= gap_nxt;
    end
  end

  // Value words
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sp_r        <= HSPDS_WORD_RST;
      actual_r    <= HSPDS_WORD_RST;
      prev_temp_r <= HSPDS_WORD_RST;
      start_cap_r <= HSPDS_WORD_RST;
      start_out_r <= HSPDS_START_INVAL;
      heat_prev_r <= 1'b0;
    end else if (CLK_EN) begin
      sp_r        <= sp_nxt;
      actual_r    <= actual_nxt;
      prev_temp_r <= ENGINE_IN.actual_temp;
      start_out_r <= start_nxt;
      heat_prev_r <= heat_req;
      if (heat_start) start_cap_r <= prev_temp_r;
    end
  end

  // Output mapping from flops; ALARM_RELAY gates alarm_r with warn_r
  assign CAL_START      = cal_start_r;
  assign HEAT_ENABLE    = control_r;
  assign ALARM_RELAY    = alarm_r & ~warn_r;
  assign SET_POINT_OUT  = sp_r;
  assign ACTUAL_OUT     = actual_r;
  assign ERROR_OUT      = {6'h00, code_r};
  assign START_TEMP_OUT = start_out_r;
  assign DEVIATION_OUT  = dev_r;

  assign STATUS_OUT.zero_pad                 = 3'h0;
  assign STATUS_OUT.channel_in_use           = chan_r;
  assign STATUS_OUT.measurement_gap_flag     = gap_r;
  assign STATUS_OUT.standby_flag             = standby_r;
  assign STATUS_OUT.reserved_info_flag       = 1'b0;
  assign STATUS_OUT.control_mode_flag        = control_r;
  assign STATUS_OUT.temperature_window_flag  = window_r;
  assign STATUS_OUT.temperature_reached_flag = reached_r;
  assign STATUS_OUT.warning_flag             = warn_r;
  assign STATUS_OUT.alarm_flag               = alarm_r;
  assign STATUS_OUT.calibration_blocked_flag = blocked_r;
  assign STATUS_OUT.calibration_running_flag = running_r;

  // Checks on the behaviour above
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_cal_go;
    CLK_EN && cal_go;
  endsequence

  sequence s_cal_running;
    cal_start_r && running_r && (cal_state_r == CAL_RUN);
  endsequence

  a_cal_start_seq: assert property (s_cal_go |=> s_cal_running)
    else $error("calibration did not start after accepted request");

  a_set_point_clamp: assert property (
    SET_POINT_OUT <= (($past(CLK_EN) && !$past(RANGE_UPPER)) ? HSPDS_SP_MAX_LOW
                                                               : HSPDS_SP_MAX_HIGH))
    else $error("set point above range maximum");

  a_channel_held: assert property (
    (CLK_EN && cal_state_r == CAL_RUN) |=> chan_r == $past(chan_r))
    else $error("channel changed during calibration");

  a_reference_stored: assert property (
    (CLK_EN && cal_store && ref_mode_r) |=>
      ref_r[$past(chan_r)] == $past(ENGINE_IN.meas_resistance))
    else $error("reference not stored after reference calibration");

  a_alarm_sticky: assert property (
    (CLK_EN && alarm_r && !clr_req) |=> alarm_r)
    else $error("alarm dropped without clear");

  a_relay_warning: assert property (warn_r |-> !ALARM_RELAY)
    else $error("alarm relay active on warning");

  a_reached_clear: assert property (
    (CLK_EN && (!heat_req || ENGINE_IN.alarm_trigger)) |=> !reached_r)
    else $error("reached flag not cleared");

  a_window_off: assert property (
    (CLK_EN && WINDOW_MODE == HSPDS_WIN_OFF) |=> !window_r)
    else $error("window flag set in off mode");

  a_info_zero: assert property (!STATUS_OUT.reserved_info_flag)
    else $error("reserved info flag set");

  a_standby_ack: assert property ((CLK_EN && clr_req) |=> standby_r)
    else $error("standby not raised on fault clear");

  a_gap_flag: assert property (
    (CLK_EN && control_nxt && !ENGINE_IN.meas_active) |=> gap_r ##0 control_r)
    else $error("measurement gap flag missing");

  a_actual_zero: assert property ((running_r || alarm_r) |-> ACTUAL_OUT == 16'h0000)
    else $error("actual value not zero in calibration or fault");

  a_start_invalid: assert property (
    ($past(CLK_EN) && !$past(heat_req)) |-> START_TEMP_OUT == HSPDS_START_INVAL)
    else $error("start temperature valid outside heating");

endmodule : hspds_status

// file: dv/hspds_engine_model.sv
// Behavioural model of the measurement engine answering calibration starts
`timescale 1ns/1ns
module hspds_engine_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Command and knobs
  input  wire logic        cal_start,
  input  wire logic [7:0]  cal_cycles,
  input  wire logic        cal_pass,
  input  wire logic [15:0] band_res,
  // Answer towards the block
  output logic             cal_done,
  output logic             cal_ok,
  output logic [15:0]      meas_resistance
);
  logic [7:0] count_r;
  logic       busy_r;

  // Resistance is only valid with done; otherwise it toggles so a stale read shows
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r          <= 1'b0;
      count_r         <= 8'h00;
      cal_done        <= 1'b0;
      cal_ok          <= 1'b0;
      meas_resistance <= 16'h0000;
    end else begin
      cal_done        <= 1'b0;
      cal_ok          <= 1'b0;
      meas_resistance <= ~meas_resistance;
      if (cal_start) begin
        busy_r  <= 1'b1;
        count_r <= cal_cycles;
      end else if (busy_r && count_r == 8'h00) begin
        busy_r          <= 1'b0;
        cal_done        <= 1'b1;
        cal_ok          <= cal_pass;
        meas_resistance <= band_res;
      end else if (busy_r) begin
        count_r <= count_r - 8'h01;
      end
    end
  end
endmodule : hspds_engine_model

// file: dv/testbench.sv
// Self-checking bench for the heat-seal process data block
`timescale 1ns/1ns
module testbench
  import hspds_pkg::*;
;
  // Stimulus, observed outputs and bookkeeping
  logic             sys_clk, reset_n, clk_en, range_upper, start_temp_enable;
  logic [1:0]       window_mode;
  logic [6:0]       tol_high, tol_low;
  logic [15:0]      set_point, band_res;
  hspds_ctrl_type   ctl;
  hspds_engine_type eng, eng_in;
  logic             cal_start, heat_enable, alarm_relay, m_done, m_ok;
  logic [15:0]      sp_out, actual_out, error_out, start_out, dev_out, m_res;
  hspds_status_type st;
  int               n_mismatch, tests_run, cycles;

  // Calibration answer from the engine model, the rest from the bench
  always_comb begin
    eng_in                 = eng;
    eng_in.cal_done        = m_done;
    eng_in.cal_ok          = m_ok;
    eng_in.meas_resistance = m_res;
  end

  hspds_status u_hspds_status (.SYS_CLK(sys_clk), .RESET_N(reset_n), .CLK_EN(clk_en),
    .SET_POINT_IN(set_point), .CONTROL_IN(ctl), .RANGE_UPPER(range_upper),
    .WINDOW_MODE(window_mode), .TOL_HIGH(tol_high), .TOL_LOW(tol_low),
    .START_TEMP_ENABLE(start_temp_enable), .ENGINE_IN(eng_in), .CAL_START(cal_start),
    .HEAT_ENABLE(heat_enable), .ALARM_RELAY(alarm_relay), .SET_POINT_OUT(sp_out),
    .ACTUAL_OUT(actual_out), .STATUS_OUT(st), .ERROR_OUT(error_out),
    .START_TEMP_OUT(start_out), .DEVIATION_OUT(dev_out));

  hspds_engine_model u_hspds_engine_model (.clk(sys_clk), .rst_n(reset_n),
    .cal_start(cal_start), .cal_cycles(8'h14), .cal_pass(1'b1), .band_res(band_res),
    .cal_done(m_done), .cal_ok(m_ok), .meas_resistance(m_res));

  // Clock and hang guard; ceiling is far above the fewer than two hundred cycles used
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Let n edges land, then look once settled
  task automatic after(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : after

  task automatic end_of_test();
    if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic wait_cal();
    int k;
    k = 0;
    while (st.calibration_running_flag !== 1'b0 && k < 100) begin
      after(1);
      k++;
    end
    check("cal running", 16'(st.calibration_running_flag), 16'h0000);
  endtask : wait_cal

  task automatic test_clamp();
    logic [15:0] req [4];
    logic [15:0] lim;
    req = '{16'h012B, 16'h012D, 16'h01F5, 16'hFFFF};
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 4; i++) begin
        @(posedge sys_clk);
        range_upper <= r[0];
        set_point   <= req[i];
        after(1);
        lim = r[0] ? HSPDS_SP_MAX_HIGH : HSPDS_SP_MAX_LOW;
        check("set point", sp_out, (req[i] > lim) ? lim : req[i]);
      end
    end
    @(posedge sys_clk);
    set_point <= 16'h00C8;
  endtask : test_clamp

  task automatic test_cal();
    @(posedge sys_clk);
    ctl.calibration_channel_select <= 3'h3;
    ctl.reference_calibration_request <= 1'b1;
    band_res <= 16'h0064;
    after(1);
    check("cal start", 16'(cal_start), 16'h0001);
    check("cal running", 16'(st.calibration_running_flag), 16'h0001);
    check("chan", 16'(st.channel_in_use), 16'h0003);
    @(posedge sys_clk);
    ctl.calibration_channel_select <= 3'h5;
    after(2);
    check("chan held", 16'(st.channel_in_use), 16'h0003);
    check("actual in cal", actual_out, 16'h0000);
    wait_cal();
    check("ref deviation", dev_out, 16'h0000);
    @(posedge sys_clk);
    ctl.reference_calibration_request <= 1'b0;
    after(2);
    check("chan new", 16'(st.channel_in_use), 16'h0005);
    @(posedge sys_clk);
    ctl.calibration_channel_select <= 3'h3;
    ctl.zero_calibration_request <= 1'b1;
    band_res <= 16'h0070;
    after(1);
    check("cal start", 16'(cal_start), 16'h0001);
    wait_cal();
    check("deviation", dev_out, 16'h000C);
    @(posedge sys_clk);
    ctl.zero_calibration_request <= 1'b0;
    eng.phase_comp_busy <= 1'b1;
    after(1);
    check("comp running", 16'(st.calibration_running_flag), 16'h0001);
    @(posedge sys_clk);
    eng.phase_comp_busy <= 1'b0;
    eng.cooling_active <= 1'b1;
    after(1);
    check("blocked cool", 16'(st.calibration_blocked_flag), 16'h0001);
    @(posedge sys_clk);
    eng.cooling_active <= 1'b0;
    ctl.heat_request <= 1'b1;
    after(1);
    check("blocked heat", 16'(st.calibration_blocked_flag), 16'h0001);
  endtask : test_cal

  task automatic test_heat();
    // Heat already requested by the previous scenario; start a fresh cycle
    @(posedge sys_clk);
    ctl.heat_request <= 1'b0;
    after(2);
    @(posedge sys_clk);
    ctl.heat_request <= 1'b1;
    after(1);
    check("control", 16'({st.control_mode_flag, heat_enable}), 16'h0003);
    check("start word", start_out, 16'h0014);
    @(posedge sys_clk);
    eng.actual_temp <= 16'h00BE;
    after(2);
    check("reached at 95", 16'(st.temperature_reached_flag), 16'h0000);
    @(posedge sys_clk);
    eng.actual_temp <= 16'h00BF;
    eng.meas_active <= 1'b0;
    after(2);
    check("reached", 16'(st.temperature_reached_flag), 16'h0001);
    check("actual", actual_out, 16'h00BF);
    check("gap", 16'(st.measurement_gap_flag), 16'h0001);
    @(posedge sys_clk);
    eng.meas_active <= 1'b1;
    after(1);
    check("gap off", 16'(st.measurement_gap_flag), 16'h0000);
    @(posedge sys_clk);
    ctl.heat_request <= 1'b0;
    eng.actual_temp <= 16'hFFFB;
    after(1);
    check("heat off", 16'({st.control_mode_flag, st.temperature_reached_flag}),
          16'h0000);
    check("start inval", start_out, HSPDS_START_INVAL);
    check("negative", actual_out, 16'hFFFB);
  endtask : test_heat

  // One window step: apply mode, heat and actual, then compare the flag
  task automatic win(input logic [1:0] m, input logic h, input logic [15:0] a, input logic e);
    @(posedge sys_clk);
    window_mode       <= m;
    ctl.heat_request  <= h;
    eng.actual_temp   <= a;
    after(2);
    check("window", 16'(st.temperature_window_flag), 16'(e));
  endtask : win

  task automatic test_window();
    win(HSPDS_WIN_OFF, 1'b0, 16'h00CB, 1'b0);
    win(HSPDS_WIN_FOLLOW, 1'b0, 16'h00CB, 1'b1);
    win(2'h3, 1'b0, 16'h00D2, 1'b0);
    tol_high <= 7'h7F;
    win(HSPDS_WIN_FOLLOW, 1'b0, 16'h0122, 1'b1);
    win(HSPDS_WIN_FOLLOW, 1'b0, 16'h0136, 1'b0);
    win(HSPDS_WIN_FOLLOW, 1'b0, 16'h00B4, 1'b0);
    tol_high <= 7'h05;
    win(HSPDS_WIN_LATCH, 1'b1, 16'h00B4, 1'b0);
    win(HSPDS_WIN_LATCH, 1'b1, 16'h00CB, 1'b1);
    win(HSPDS_WIN_LATCH, 1'b0, 16'h00B4, 1'b1);
    win(HSPDS_WIN_LATCH, 1'b1, 16'h00B4, 1'b0);
    win(HSPDS_WIN_LATCH, 1'b1, 16'h00CB, 1'b1);
    win(HSPDS_WIN_LATCH, 1'b1, 16'h00B4, 1'b0);
    // Re-entry after an exit in the same heat cycle must not set the flag again
    win(HSPDS_WIN_LATCH, 1'b1, 16'h00CB, 1'b0);
  endtask : test_window

  // Raise an alarm of either class, then clear it through the standby handshake
  task automatic alarm(input logic warn);
    @(posedge sys_clk);
    eng.alarm_trigger <= 1'b1;
    eng.alarm_is_warning <= warn;
    eng.alarm_code <= 10'h155;
    @(posedge sys_clk);
    eng.alarm_trigger <= 1'b0;
    after(3);
    check("alarm", 16'({st.alarm_flag, st.warning_flag}),
          {14'h0000, 1'b1, warn});
    check("relay", 16'(alarm_relay), 16'(!warn));
    check("code", error_out, 16'h0155);
    check("actual", actual_out, 16'h0000);
    check("reached", 16'({st.temperature_reached_flag, st.control_mode_flag}), 16'h0000);
    @(posedge sys_clk);
    ctl.fault_clear_request <= 1'b1;
    after(1);
    check("clear", 16'({st.alarm_flag, st.standby_flag}), 16'h0001);
    @(posedge sys_clk);
    ctl.fault_clear_request <= 1'b0;
    after(2);
    check("standby off", 16'(st.standby_flag), 16'h0000);
  endtask : alarm

  // Time-zero values, reset, then the scenarios in turn
  initial begin
    {sys_clk, reset_n, range_upper, n_mismatch, tests_run, cycles} = '0;
    {clk_en, start_temp_enable} = 2'b11;
    {window_mode, ctl, eng} = '0;
    {tol_high, tol_low} = {7'h05, 7'h05};
    set_point = 16'h00C8;
    band_res = 16'h0000;
    eng.meas_active = 1'b1;
    eng.actual_temp = 16'h0014;
    after(16);
    check("start rst", start_out, HSPDS_START_INVAL);
    check("status rst", st, 16'h0000);
    @(posedge sys_clk);
    reset_n <= 1'b1;
    test_clamp();
    test_cal();
    test_heat();
    test_window();
    alarm(1'b0);
    alarm(1'b1);
    // Pause only counts without heat, so the heat cycle left over is ended first
    @(posedge sys_clk);
    ctl.heat_request <= 1'b0;
    ctl.measurement_pause_request <= 1'b1;
    after(1);
    check("pause standby", 16'({st.standby_flag, st.reserved_info_flag}),
          16'h0002);
    @(posedge sys_clk);
    ctl.measurement_pause_request <= 1'b0;
    after(2);
    check("pause off", 16'(st.standby_flag), 16'h0000);
    end_of_test();
  end
endmodule : testbench
